// ### hdl/alarm_pin_pkg.sv
`default_nettype none
package alarm_pin_pkg;

    // register word width
    localparam int unsigned REG_W = 8;

    // register addresses on the configuration port
    localparam logic [7:0] ADDR_PIN_ENABLES  = 8'h14;
    localparam logic [7:0] ADDR_ACTIVE_PINS  = 8'h15;
    localparam logic [7:0] ADDR_POLARITY     = 8'h16;
    localparam logic [7:0] ADDR_LOSS_MASKS   = 8'h17;
    localparam logic [7:0] ADDR_BLOCK_STATUS = 8'h80;

    // reset values
    localparam logic [7:0] RST_PIN_ENABLES = 8'h3C;
    localparam logic [7:0] RST_ACTIVE_PINS = 8'hFF;
    localparam logic [7:0] RST_POLARITY    = 8'hDF;
    localparam logic [7:0] RST_LOSS_MASKS  = 8'h1F;

    // writable bits; the rest keep their reset value and ignore writes
    localparam logic [7:0] WR_PIN_ENABLES = 8'h3F;
    localparam logic [7:0] WR_ACTIVE_PINS = 8'h1F;
    localparam logic [7:0] WR_POLARITY    = 8'h0F;
    localparam logic [7:0] WR_LOSS_MASKS  = 8'h1F;

    // answer for an address that holds nothing
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // pin enable register fields
    localparam int unsigned BIT_INT_PIN   = 0;
    localparam int unsigned BIT_LOCK_PIN  = 1;
    localparam int unsigned BIT_BAD_LSB   = 2;
    localparam int unsigned BIT_ALARM_PIN = 5;

    // active pin register fields
    localparam int unsigned BIT_SEL_PIN_CTL = 0;
    localparam int unsigned BIT_ACTV_LSB    = 1;

    // polarity register fields
    localparam int unsigned POL_INT  = 0;
    localparam int unsigned POL_LOCK = 1;
    localparam int unsigned POL_BAD  = 2;
    localparam int unsigned POL_ACTV = 3;

    // block status register fields
    localparam int unsigned ST_INT_BIT   = 7;
    localparam int unsigned ST_SEL_LSB   = 5;
    localparam int unsigned ST_FLAGS_LSB = 0;

    // counts of monitored things
    localparam int unsigned NUM_INPUTS = 4;
    localparam int unsigned NUM_BAD    = 3;
    localparam int unsigned NUM_LOSS   = 5;

    typedef enum logic [1:0] {
        SRC_AUTO    = 2'b00,
        SRC_MAN_REG = 2'b01,
        SRC_MAN_PIN = 2'b10
    } sel_source_t;

endpackage
`default_nettype wire

// ### hdl/sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_two_flop: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule // sync_two_flop
`default_nettype wire

// ### hdl/pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic [WIDTH-1:0] asserted,
    input  wire logic [WIDTH-1:0] activeHigh,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOe
);

    logic [WIDTH-1:0] pinLevel;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_driver: WIDTH must be at least 1");
    end

    // polarity applied per pin ahead of the output flop
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        assign pinLevel[i] = activeHigh[i] ? asserted[i] : ~asserted[i];
    end

    // one process owns the outputs; registered so the pads never see a decode glitch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else begin
            pinOut <= pinLevel;
            pinOe  <= enable;
        end
    end

endmodule // pin_driver
`default_nettype wire

// ### hdl/alarm_pin_and_interrupt_mask_control.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_pin_and_interrupt_mask_control (
    input  wire logic       clk,
    input  wire logic       rst_n,
    // configuration port, register side
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    // clock selection
    input  wire logic       manualSelect,
    input  wire logic [1:0] selectionRegisterField,
    input  wire logic [1:0] selectionInputPinsIn,
    output logic      [1:0] selectedInput,
    // monitor status, same clock domain
    input  wire logic [3:0] activeStatusBits,
    input  wire logic [2:0] badClockStatus,
    input  wire logic       summaryAlarmStatus,
    input  wire logic       lockLossStatus,
    input  wire logic [4:0] signalLossFlags,
    // shared select pins, output side (bit 0 input3, bit 1 input4)
    output logic      [1:0] selPinOut,
    output logic      [1:0] selPinOe,
    // dedicated active pins (bit 0 input1, bit 1 input2)
    output logic      [1:0] activePinOut,
    output logic      [1:0] activePinOe,
    output logic      [2:0] badPinOut,
    output logic      [2:0] badPinOe,
    output logic            lockLossPinOut,
    output logic            lockLossPinOe,
    output logic            interruptAlarmPinOut,
    output logic            interruptAlarmPinOe,
    output logic            interruptStatus
);

    localparam int unsigned NI = alarm_pin_pkg::NUM_INPUTS;
    localparam int unsigned NB = alarm_pin_pkg::NUM_BAD;
    localparam int unsigned NL = alarm_pin_pkg::NUM_LOSS;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] pinEnables_q;
    logic [7:0] activePins_q;
    logic [7:0] polarity_q;
    logic [7:0] lossMasks_q;

    logic       wrPinEnables;
    logic       wrActivePins;
    logic       wrPolarity;
    logic       wrLossMasks;

    assign wrPinEnables = regWrEn && (regAddr == alarm_pin_pkg::ADDR_PIN_ENABLES);
    assign wrActivePins = regWrEn && (regAddr == alarm_pin_pkg::ADDR_ACTIVE_PINS);
    assign wrPolarity   = regWrEn && (regAddr == alarm_pin_pkg::ADDR_POLARITY);
    assign wrLossMasks  = regWrEn && (regAddr == alarm_pin_pkg::ADDR_LOSS_MASKS);

    // read-only bits keep their reset value through any write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinEnables_q <= alarm_pin_pkg::RST_PIN_ENABLES;
        end else if (wrPinEnables) begin
            pinEnables_q <= (regWrData & alarm_pin_pkg::WR_PIN_ENABLES)
                          | (alarm_pin_pkg::RST_PIN_ENABLES & ~alarm_pin_pkg::WR_PIN_ENABLES);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activePins_q <= alarm_pin_pkg::RST_ACTIVE_PINS;
        end else if (wrActivePins) begin
            activePins_q <= (regWrData & alarm_pin_pkg::WR_ACTIVE_PINS)
                          | (alarm_pin_pkg::RST_ACTIVE_PINS & ~alarm_pin_pkg::WR_ACTIVE_PINS);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            polarity_q <= alarm_pin_pkg::RST_POLARITY;
        end else if (wrPolarity) begin
            polarity_q <= (regWrData & alarm_pin_pkg::WR_POLARITY)
                        | (alarm_pin_pkg::RST_POLARITY & ~alarm_pin_pkg::WR_POLARITY);
        end
    end

    // only the mask bits live here; the flags belong to the monitor
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lossMasks_q <= alarm_pin_pkg::RST_LOSS_MASKS;
        end else if (wrLossMasks) begin
            lossMasks_q <= (regWrData & alarm_pin_pkg::WR_LOSS_MASKS)
                         | (alarm_pin_pkg::RST_LOSS_MASKS & ~alarm_pin_pkg::WR_LOSS_MASKS);
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    logic          intPinEn;
    logic          lockPinEn;
    logic          alarmPinEn;
    logic [NB-1:0] badPinEn;
    logic          selPinCtl;
    logic [NI-1:0] activePinEn;
    logic          polActv;
    logic          polBad;
    logic          polLock;
    logic          polInt;
    logic [NL-1:0] lossMask;

    assign intPinEn    = pinEnables_q[alarm_pin_pkg::BIT_INT_PIN];
    assign lockPinEn   = pinEnables_q[alarm_pin_pkg::BIT_LOCK_PIN];
    assign alarmPinEn  = pinEnables_q[alarm_pin_pkg::BIT_ALARM_PIN];
    assign badPinEn    = pinEnables_q[alarm_pin_pkg::BIT_BAD_LSB +: NB];
    assign selPinCtl   = activePins_q[alarm_pin_pkg::BIT_SEL_PIN_CTL];
    assign activePinEn = activePins_q[alarm_pin_pkg::BIT_ACTV_LSB +: NI];
    assign polActv     = polarity_q[alarm_pin_pkg::POL_ACTV];
    assign polBad      = polarity_q[alarm_pin_pkg::POL_BAD];
    assign polLock     = polarity_q[alarm_pin_pkg::POL_LOCK];
    assign polInt      = polarity_q[alarm_pin_pkg::POL_INT];
    assign lossMask    = lossMasks_q[NL-1:0];

    // ------------------------------------------------------------------
    // clock selection source
    // ------------------------------------------------------------------
    logic [1:0]                 selPinsSync;
    alarm_pin_pkg::sel_source_t selSource;
    logic [1:0]                 selectedInput_d;

    // select pins come from the board, outside this clock
    sync_two_flop #(
        .WIDTH (2)
    ) u_sel_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (selectionInputPinsIn),
        .syncOut (selPinsSync)
    );

    always_comb begin
        if (!manualSelect) begin
            selSource = alarm_pin_pkg::SRC_AUTO;
        end else if (selPinCtl) begin
            selSource = alarm_pin_pkg::SRC_MAN_PIN;
        end else begin
            selSource = alarm_pin_pkg::SRC_MAN_REG;
        end
    end

    // automatic mode keeps the register field as a harmless default
    always_comb begin
        unique case (selSource)
            alarm_pin_pkg::SRC_MAN_PIN: selectedInput_d = selPinsSync;
            alarm_pin_pkg::SRC_MAN_REG: selectedInput_d = selectionRegisterField;
            alarm_pin_pkg::SRC_AUTO:    selectedInput_d = selectionRegisterField;
            default:                    selectedInput_d = selectionRegisterField;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            selectedInput <= 2'h0;
        end else begin
            selectedInput <= selectedInput_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    logic [NL-1:0] unmaskedLoss;
    logic          intStatus_d;

    // a set mask bit drops that flag from the interrupt and from the block status flags
    for (genvar i = 0; i < NL; i++) begin : g_loss_gate
        assign unmaskedLoss[i] = signalLossFlags[i] & ~lossMask[i];
    end

    assign intStatus_d = |unmaskedLoss;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interruptStatus <= 1'b0;
        end else begin
            interruptStatus <= intStatus_d;
        end
    end

    // ------------------------------------------------------------------
    // active indicator pins
    // ------------------------------------------------------------------
    logic [NI-1:0] actvDrive;
    logic [NI-1:0] actvOut;
    logic [NI-1:0] actvOe;
    logic          sharedAsOutput;

    // in manual pin mode the shared pins are select inputs
    assign sharedAsOutput = !manualSelect;

    // enables count only with pin control set
    assign actvDrive[0] = activePinEn[0] & selPinCtl;
    assign actvDrive[1] = activePinEn[1] & selPinCtl;
    assign actvDrive[2] = activePinEn[2] & selPinCtl & sharedAsOutput;
    assign actvDrive[3] = activePinEn[3] & selPinCtl & sharedAsOutput;

    pin_driver #(
        .WIDTH (NI)
    ) u_active_pins (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (actvDrive),
        .asserted   (activeStatusBits),
        .activeHigh ({NI{polActv}}),
        .pinOut     (actvOut),
        .pinOe      (actvOe)
    );

    assign activePinOut = actvOut[1:0];
    assign activePinOe  = actvOe[1:0];
    assign selPinOut    = actvOut[3:2];
    assign selPinOe     = actvOe[3:2];

    // ------------------------------------------------------------------
    // bad clock, lock loss and interrupt/alarm pins
    // ------------------------------------------------------------------
    pin_driver #(
        .WIDTH (NB)
    ) u_bad_pins (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (badPinEn),
        .asserted   (badClockStatus),
        .activeHigh ({NB{polBad}}),
        .pinOut     (badPinOut),
        .pinOe      (badPinOe)
    );

    pin_driver #(
        .WIDTH (1)
    ) u_lock_pin (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (lockPinEn),
        .asserted   (lockLossStatus),
        .activeHigh (polLock),
        .pinOut     (lockLossPinOut),
        .pinOe      (lockLossPinOe)
    );

    logic intPinDrive;
    logic intPinLevel;
    logic intPinHigh;

    // interrupt request wins; the summary alarm only shows when it is off
    assign intPinDrive = intPinEn | alarmPinEn;
    assign intPinLevel = intPinEn ? intStatus_d : summaryAlarmStatus;
    assign intPinHigh  = intPinEn ? polInt : polBad;

    pin_driver #(
        .WIDTH (1)
    ) u_int_pin (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (intPinDrive),
        .asserted   (intPinLevel),
        .activeHigh (intPinHigh),
        .pinOut     (interruptAlarmPinOut),
        .pinOe      (interruptAlarmPinOe)
    );

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------
    logic [7:0] blockStatus;
    logic [7:0] readData_d;

    always_comb begin
        blockStatus = 8'h00;
        blockStatus[alarm_pin_pkg::ST_INT_BIT] = interruptStatus;
        blockStatus[alarm_pin_pkg::ST_SEL_LSB +: 2] = selectedInput;
        blockStatus[alarm_pin_pkg::ST_FLAGS_LSB +: NL] = unmaskedLoss;
    end

    always_comb begin
        unique case (regAddr)
            alarm_pin_pkg::ADDR_PIN_ENABLES:  readData_d = pinEnables_q;
            alarm_pin_pkg::ADDR_ACTIVE_PINS:  readData_d = activePins_q;
            alarm_pin_pkg::ADDR_POLARITY:     readData_d = polarity_q;
            alarm_pin_pkg::ADDR_LOSS_MASKS:   readData_d = lossMasks_q;
            alarm_pin_pkg::ADDR_BLOCK_STATUS: readData_d = blockStatus;
            default:                          readData_d = alarm_pin_pkg::UNMAPPED_DATA;
        endcase
    end

    // data holds until the next read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= readData_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
        end
    end

endmodule // alarm_pin_and_interrupt_mask_control
`default_nettype wire

// ### dv/alarm_pin_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_pin_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       manualSelect,
    input wire logic [1:0] selectionRegisterField,
    input wire logic [1:0] selectionInputPinsIn,
    input wire logic [1:0] selectedInput,
    input wire logic [2:0] badClockStatus,
    input wire logic       summaryAlarmStatus,
    input wire logic [4:0] signalLossFlags,
    input wire logic [1:0] selPinOe,
    input wire logic [1:0] activePinOe,
    input wire logic [2:0] badPinOut,
    input wire logic [2:0] badPinOe,
    input wire logic       interruptAlarmPinOut,
    input wire logic       interruptAlarmPinOe,
    input wire logic       interruptStatus
);
    // shadow copies of the writable fields, updated on the same edge as the design
    logic [5:0] penQ;
    logic [4:0] actQ;
    logic [4:0] mskQ;
    logic [3:0] polQ;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            penQ <= 6'h3C;
            actQ <= 5'h1F;
            polQ <= 4'hF;
            mskQ <= 5'h1F;
        end else if (regWrEn) begin
            case (regAddr)
                8'h14: penQ <= regWrData[5:0];
                8'h15: actQ <= regWrData[4:0];
                8'h16: polQ <= regWrData[3:0];
                8'h17: mskQ <= regWrData[4:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_int_unmasked: assert property (
        $past(rst_n) |-> interruptStatus == $past(|(signalLossFlags & ~mskQ)))
        else $error("interrupt status differs from unmasked loss flags");
    chk_int_pin_oe: assert property (
        $past(rst_n) |-> interruptAlarmPinOe == $past(penQ[0] | penQ[5]))
        else $error("interrupt pin enable wrong");
    chk_int_pin_level: assert property (
        $past(rst_n) && $past(penQ[0]) |-> interruptAlarmPinOut == (interruptStatus ~^ $past(polQ[0])))
        else $error("interrupt pin level wrong");
    chk_alarm_pin_level: assert property (
        $past(rst_n) && $past(!penQ[0] && penQ[5])
        |-> interruptAlarmPinOut == $past(summaryAlarmStatus ~^ polQ[2]))
        else $error("alarm pin level wrong");
    chk_bad_pins: assert property (
        $past(rst_n) |-> badPinOe == $past(penQ[4:2])
        && (badPinOut & badPinOe) == ($past(badClockStatus ^ {3{~polQ[2]}}) & badPinOe))
        else $error("bad clock pins wrong");
    chk_active_oe: assert property (
        $past(rst_n) |-> activePinOe == $past(actQ[2:1] & {2{actQ[0]}}))
        else $error("active pin enables wrong");
    chk_shared_oe: assert property (
        $past(rst_n) |-> selPinOe == $past(actQ[4:3] & {2{actQ[0] & ~manualSelect}}))
        else $error("shared pin enables wrong");
    chk_select_reg: assert property (
        $past(rst_n) && $past(!(manualSelect && actQ[0]))
        |-> selectedInput == $past(selectionRegisterField))
        else $error("register selection not followed");
    chk_select_pins: assert property (
        (manualSelect && actQ[0] && $stable(selectionInputPinsIn)) [*3]
        |=> selectedInput == $past(selectionInputPinsIn))
        else $error("pin selection not followed");
endmodule // alarm_pin_assertions
bind alarm_pin_and_interrupt_mask_control alarm_pin_assertions i_alarm_pin_assertions (
    .clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .manualSelect(manualSelect), .selectionRegisterField(selectionRegisterField),
    .selectionInputPinsIn(selectionInputPinsIn), .selectedInput(selectedInput),
    .badClockStatus(badClockStatus), .summaryAlarmStatus(summaryAlarmStatus),
    .signalLossFlags(signalLossFlags), .selPinOe(selPinOe), .activePinOe(activePinOe),
    .badPinOut(badPinOut), .badPinOe(badPinOe), .interruptAlarmPinOut(interruptAlarmPinOut),
    .interruptAlarmPinOe(interruptAlarmPinOe), .interruptStatus(interruptStatus)
);
`default_nettype wire

// ### dv/alarm_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_board_model (
    input  wire logic [1:0] selDrive,
    input  wire logic [1:0] selPinOut,
    input  wire logic [1:0] selPinOe,
    input  wire logic       intOut,
    input  wire logic       intOe,
    output logic      [1:0] selWire,
    output logic            intWire
);
    // board yields the shared pins while the device drives them
    assign selWire = (selPinOe & selPinOut) | (~selPinOe & selDrive);
    // pull-up on the interrupt line
    assign intWire = intOe ? intOut : 1'b1;
endmodule // alarm_board_model
`default_nettype wire

// ### dv/alarm_pin_and_interrupt_mask_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_pin_and_interrupt_mask_control_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       regWrEn = 1'b0, regRdEn = 1'b0, manualSelect = 1'b0;
    logic       summaryAlarmStatus = 1'b0, lockLossStatus = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [1:0] selectionRegisterField = 2'h0, selDrive = 2'h0;
    logic [3:0] activeStatusBits = 4'h0;
    logic [2:0] badClockStatus = 3'h0, badPinOut, badPinOe;
    logic [4:0] signalLossFlags = 5'h00;
    logic       regRdValid, lockLossPinOut, lockLossPinOe, intOut, intOe, interruptStatus;
    logic       intWire;
    logic [1:0] selectedInput, selPinOut, selPinOe, activePinOut, activePinOe, selWire;
    int         nFail = 0, testsRun = 0, cycles = 0;
    always #10 clk = ~clk;
    alarm_pin_and_interrupt_mask_control i_alarm_pin_and_interrupt_mask_control (
        .clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .manualSelect(manualSelect), .selectionRegisterField(selectionRegisterField),
        .selectionInputPinsIn(selWire), .selectedInput(selectedInput),
        .activeStatusBits(activeStatusBits), .badClockStatus(badClockStatus),
        .summaryAlarmStatus(summaryAlarmStatus), .lockLossStatus(lockLossStatus),
        .signalLossFlags(signalLossFlags), .selPinOut(selPinOut), .selPinOe(selPinOe),
        .activePinOut(activePinOut), .activePinOe(activePinOe), .badPinOut(badPinOut),
        .badPinOe(badPinOe), .lockLossPinOut(lockLossPinOut), .lockLossPinOe(lockLossPinOe),
        .interruptAlarmPinOut(intOut), .interruptAlarmPinOe(intOe),
        .interruptStatus(interruptStatus)
    );
    alarm_board_model i_alarm_board_model (
        .selDrive(selDrive), .selPinOut(selPinOut), .selPinOe(selPinOe),
        .intOut(intOut), .intOe(intOe), .selWire(selWire), .intWire(intWire)
    );
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check({7'h00, regRdValid}, 8'h01);
        check(regRdData, exp);
    endtask
    // pins lag a register write by one edge, selection by three
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            nFail++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h14, 8'h3C);
        rd(8'h15, 8'hFF);
        rd(8'h16, 8'hDF);
        rd(8'h17, 8'h1F);
        rd(8'h42, 8'h00);
        wr(8'h16, 8'h00);
        rd(8'h16, 8'hD0);
        $display("test registers done");
        wr(8'h14, 8'h01);
        wr(8'h16, 8'h0F);
        for (int i = 0; i < 5; i++) begin
            wr(8'h17, 8'h1F ^ (8'h01 << i));
            signalLossFlags <= 5'h1F ^ (5'h01 << i);
            settle();
            check({5'h00, interruptStatus, intOe, intWire}, 8'h02);
            @(posedge clk);
            signalLossFlags <= 5'h01 << i;
            settle();
            check({5'h00, interruptStatus, intOe, intWire}, 8'h07);
        end
        wr(8'h16, 8'h0E);
        settle();
        check({5'h00, interruptStatus, intOe, intWire}, 8'h06);
        $display("test masks done");
        wr(8'h16, 8'h0B);
        wr(8'h14, 8'h20);
        summaryAlarmStatus <= 1'b1;
        settle();
        check({6'h00, intOe, intWire}, 8'h02);
        wr(8'h14, 8'h21);
        settle();
        check({6'h00, intOe, intWire}, 8'h03);
        wr(8'h14, 8'h1E);
        badClockStatus <= 3'h5;
        lockLossStatus <= 1'b1;
        settle();
        check({2'h0, badPinOe, badPinOut}, 8'h3A);
        check({6'h00, lockLossPinOe, lockLossPinOut}, 8'h03);
        rd(8'h80, 8'h90);
        wr(8'h17, 8'hFF);
        rd(8'h17, 8'h1F);
        rd(8'h80, 8'h00);
        wr(8'h17, 8'h0F);
        rd(8'h80, 8'h90);
        $display("test alarm pins done");
        wr(8'h15, 8'h1F);
        activeStatusBits <= 4'h9;
        settle();
        check({activePinOe, activePinOut, selPinOe, selPinOut}, 8'hDE);
        wr(8'h15, 8'h15);
        wr(8'h16, 8'h03);
        settle();
        check({activePinOe, activePinOut & activePinOe, selPinOe, selPinOut & selPinOe},
              8'hA8);
        wr(8'h15, 8'h1E);
        manualSelect <= 1'b1;
        selectionRegisterField <= 2'h2;
        selDrive <= 2'h1;
        settle();
        check({4'h0, activePinOe, selPinOe}, 8'h00);
        check({6'h00, selectedInput}, 8'h02);
        wr(8'h15, 8'h1F);
        settle();
        check({6'h00, selectedInput}, 8'h01);
        $display("test active pins and selection done");
        stop_test();
    end
endmodule // alarm_pin_and_interrupt_mask_control_bench
`default_nettype wire
